// >>> vdi_pkg.sv
// Constants for the voltage detect interrupt flag block
package vdi_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] CLEAR_OFS = 4'h8;
  localparam logic [3:0] MASK_OFS = 4'hC;
  // Control fields
  localparam int CTRL_DET0_RESET_MODE = 0;
  localparam int CTRL_DET1_RESET_MODE = 1;
  localparam int CTRL_DET1_ENABLE = 2;
  // Status fields
  localparam int ST_DET0_SEEN = 0;
  localparam int ST_DET1_SEEN = 1;
  localparam int ST_DET0_BELOW = 2;
  localparam int ST_DET1_BELOW = 3;
  localparam int ST_DET1_READY = 4;
  localparam int ST_DET0_RESET_MODE = 5;
  localparam int ST_INT_RESET = 6;
  // Clear register fields (same bits as the seen flags)
  localparam int CLR_DET0 = 0;
  localparam int CLR_DET1 = 1;
  // Reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] MASK_RESET = 2'h3;
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int DET1_SETTLE_US = 500;
  localparam int DET1_SETTLE_CYC = DET1_SETTLE_US * (CLK_HZ / 1000000);
  // Detector one enable sequence, Gray coded except the two-bit step from ACTIVE back to OFF
  typedef enum logic [1:0] {
    VDI_D1_OFF = 2'b00,
    VDI_D1_SETTLE = 2'b01,
    VDI_D1_ACTIVE = 2'b11
  } vdi_d1_state_e;
endpackage

// >>> vdi_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module vdi_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level_r,
  output logic changed
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;
  logic level_nxt;

  // Level follows once stages two and three agree
  always_comb
  begin
    s1_nxt = pin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    changed = (s2_r == s3_r) && (s3_r != level_r);
  end

  // Register stage
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      level_r <= level_nxt;
    end
  end
endmodule // vdi_sync

// >>> vdi_flags.sv
// Interrupt flags, mode handling and register slave for two voltage detectors
`timescale 1ns/100ps
module vdi_flags #(
  parameter int SETTLE_CYC = vdi_pkg::DET1_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic det0_cmp_below,
  input wire logic det1_cmp_below,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic shared_voltage_irq_vector,
  output logic voltage_detect_irq_request,
  output logic internal_reset_r
);
  // Synchronised comparator levels
  logic det0_below_threshold_flag;
  logic det1_below_threshold_flag;
  logic det0_change;
  logic det1_change;

  // Register state
  logic det0_reset_mode_r;
  logic det0_reset_mode_nxt;
  logic det1_reset_mode_r;
  logic det1_reset_mode_nxt;
  logic det1_enable_r;
  logic det1_enable_nxt;
  logic det0_irq_seen_flag;
  logic det0_seen_nxt;
  logic det1_irq_seen_flag;
  logic det1_seen_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic internal_reset_nxt;
  logic irq_nxt;
  logic req_nxt;
  logic ack_nxt;
  logic [31:0] dat_nxt;

  // Detector one sequence
  vdi_pkg::vdi_d1_state_e d1_state_r;
  vdi_pkg::vdi_d1_state_e d1_state_nxt;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt_r;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt_nxt;

  // Bus decode and event terms
  logic bus_req;
  logic wr_ctrl;
  logic wr_status;
  logic wr_clear;
  logic wr_mask;
  logic det0_clear;
  logic det1_clear;
  logic det0_event;
  logic det1_event;
  logic det1_ready;

  // Byte lane zero write strobe to a given offset
  function automatic logic lane0_write(input logic [3:0] adr, input logic [3:0] ofs);
    lane0_write = bus_req && wb_we_i && wb_sel_i[0] && (adr == ofs);
  endfunction

  // Comparator synchronisers
  vdi_sync u_sync0 (
    .clk(clk),
    .resetn(resetn),
    .pin(det0_cmp_below),
    .level_r(det0_below_threshold_flag),
    .changed(det0_change)
  );

  vdi_sync u_sync1 (
    .clk(clk),
    .resetn(resetn),
    .pin(det1_cmp_below),
    .level_r(det1_below_threshold_flag),
    .changed(det1_change)
  );

  // Bus strobes; a request is serviced once, in the cycle before ack
  always_comb
  begin
    bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr_ctrl = lane0_write(wb_adr_i, vdi_pkg::CTRL_OFS);
    wr_status = lane0_write(wb_adr_i, vdi_pkg::STATUS_OFS);
    wr_clear = lane0_write(wb_adr_i, vdi_pkg::CLEAR_OFS);
    wr_mask = lane0_write(wb_adr_i, vdi_pkg::MASK_OFS);
    det0_clear = (wr_clear || wr_status) && wb_dat_i[vdi_pkg::CLR_DET0];
    det1_clear = (wr_clear || wr_status) && wb_dat_i[vdi_pkg::CLR_DET1];
  end

  // Detector one enable and settle sequence
  always_comb
  begin
    d1_state_nxt = d1_state_r;
    settle_cnt_nxt = settle_cnt_r;
    case (d1_state_r)
      vdi_pkg::VDI_D1_OFF:
      begin
        settle_cnt_nxt = '0;
        if (det1_enable_r)
        begin
          d1_state_nxt = vdi_pkg::VDI_D1_SETTLE;
        end
      end
      vdi_pkg::VDI_D1_SETTLE:
      begin
        if (!det1_enable_r)
        begin
          d1_state_nxt = vdi_pkg::VDI_D1_OFF;
        end
        else if (settle_cnt_r == $bits(settle_cnt_r)'(SETTLE_CYC - 1))
        begin
          d1_state_nxt = vdi_pkg::VDI_D1_ACTIVE;
        end
        else
        begin
          settle_cnt_nxt = settle_cnt_r + 1'b1;
        end
      end
      vdi_pkg::VDI_D1_ACTIVE:
      begin
        if (!det1_enable_r)
        begin
          d1_state_nxt = vdi_pkg::VDI_D1_OFF;
        end
      end
      default:
      begin
        d1_state_nxt = vdi_pkg::VDI_D1_OFF;
      end
    endcase
  end

  // Mode bits, enable, mask and internal reset
  always_comb
  begin
    det1_ready = (d1_state_r == vdi_pkg::VDI_D1_ACTIVE);
    // Reset mode holds the internal reset while below; for detector one only until its forced disable takes it out of ACTIVE
    internal_reset_nxt = (det0_reset_mode_r && det0_below_threshold_flag) ||
                         (det1_ready && det1_reset_mode_r && det1_below_threshold_flag);
    det0_reset_mode_nxt = wr_ctrl ? wb_dat_i[vdi_pkg::CTRL_DET0_RESET_MODE] : det0_reset_mode_r;
    det1_reset_mode_nxt = wr_ctrl ? wb_dat_i[vdi_pkg::CTRL_DET1_RESET_MODE] : det1_reset_mode_r;
    det1_enable_nxt = wr_ctrl ? wb_dat_i[vdi_pkg::CTRL_DET1_ENABLE] : det1_enable_r;
    // Internal reset beats software, so detector one must be set up again
    if (internal_reset_r)
    begin
      det0_reset_mode_nxt = 1'b1;
      det1_enable_nxt = 1'b0;
    end
    mask_nxt = wr_mask ? wb_dat_i[1:0] : mask_r;
  end

  // Seen flags, shared interrupt level and request pulse
  always_comb
  begin
    // Either crossing direction is an interrupt request in interrupt mode, for detector one only once it is ready (ACTIVE)
    det0_event = det0_change && !det0_reset_mode_r;
    det1_event = det1_change && det1_ready && !det1_reset_mode_r;
    // Set wins over a same-cycle clear, so no event is lost to a late handler
    det0_seen_nxt = det0_event || (det0_irq_seen_flag && !det0_clear);
    det1_seen_nxt = det1_event || (det1_irq_seen_flag && !det1_clear);
    // One shared output for both detectors, built from next values to avoid a lag
    irq_nxt = (det0_seen_nxt && mask_nxt[vdi_pkg::ST_DET0_SEEN]) ||
              (det1_seen_nxt && mask_nxt[vdi_pkg::ST_DET1_SEEN]);
    req_nxt = det0_event || det1_event;
  end

  // Bus answer and read data
  always_comb
  begin
    ack_nxt = bus_req;
    dat_nxt = 32'h0000_0000;
    if (bus_req && !wb_we_i)
    begin
      case (wb_adr_i)
        vdi_pkg::CTRL_OFS:
        begin
          dat_nxt[vdi_pkg::CTRL_DET0_RESET_MODE] = det0_reset_mode_r;
          dat_nxt[vdi_pkg::CTRL_DET1_RESET_MODE] = det1_reset_mode_r;
          dat_nxt[vdi_pkg::CTRL_DET1_ENABLE] = det1_enable_r;
        end
        vdi_pkg::STATUS_OFS:
        begin
          dat_nxt[vdi_pkg::ST_DET0_SEEN] = det0_irq_seen_flag;
          dat_nxt[vdi_pkg::ST_DET1_SEEN] = det1_irq_seen_flag;
          dat_nxt[vdi_pkg::ST_DET0_BELOW] = det0_below_threshold_flag;
          dat_nxt[vdi_pkg::ST_DET1_BELOW] = det1_below_threshold_flag && det1_ready;
          dat_nxt[vdi_pkg::ST_DET1_READY] = det1_ready;
          dat_nxt[vdi_pkg::ST_DET0_RESET_MODE] = det0_reset_mode_r;
          dat_nxt[vdi_pkg::ST_INT_RESET] = internal_reset_r;
        end
        vdi_pkg::MASK_OFS:
        begin
          dat_nxt[1:0] = mask_r;
        end
        default:
        begin
          dat_nxt = 32'h0000_0000; // Clear register and unmapped words read zero
        end
      endcase
    end
  end

  // Detector one sequence registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      d1_state_r <= vdi_pkg::VDI_D1_OFF;
      settle_cnt_r <= '0;
    end
    else
    begin
      d1_state_r <= d1_state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      det0_reset_mode_r <= vdi_pkg::CTRL_RESET[vdi_pkg::CTRL_DET0_RESET_MODE];
      det1_reset_mode_r <= vdi_pkg::CTRL_RESET[vdi_pkg::CTRL_DET1_RESET_MODE];
      det1_enable_r <= vdi_pkg::CTRL_RESET[vdi_pkg::CTRL_DET1_ENABLE];
      mask_r <= vdi_pkg::MASK_RESET;
    end
    else
    begin
      det0_reset_mode_r <= det0_reset_mode_nxt;
      det1_reset_mode_r <= det1_reset_mode_nxt;
      det1_enable_r <= det1_enable_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Internal reset level, registered so it never glitches on the output
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      internal_reset_r <= 1'b0;
    end
    else
    begin
      internal_reset_r <= internal_reset_nxt;
    end
  end

  // Seen flags and interrupt outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      det0_irq_seen_flag <= 1'b0;
      det1_irq_seen_flag <= 1'b0;
      shared_voltage_irq_vector <= 1'b0;
      voltage_detect_irq_request <= 1'b0;
    end
    else
    begin
      det0_irq_seen_flag <= det0_seen_nxt;
      det1_irq_seen_flag <= det1_seen_nxt;
      shared_voltage_irq_vector <= irq_nxt;
      voltage_detect_irq_request <= req_nxt;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= dat_nxt;
    end
  end
endmodule // vdi_flags

// >>> vdi_flags_chk.sv
// Port-level assertions for the voltage detect flag block
`timescale 1ns/100ps
module vdi_flags_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic det0_cmp_below,
  input wire logic det1_cmp_below,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic shared_voltage_irq_vector,
  input wire logic voltage_detect_irq_request,
  input wire logic internal_reset_r
);
  logic [7:0] hist_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Recent comparator history, any detector below
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) hist_r <= 8'h00;
    else hist_r <= {hist_r[6:0], det0_cmp_below | det1_cmp_below};
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_answer; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_req_pulse; voltage_detect_irq_request |=> !voltage_detect_irq_request; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than a pulse");
  property p_vec_fall; $fell(shared_voltage_irq_vector) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i); endproperty
  a_vec_fall: assert property (p_vec_fall) else $error("vector dropped without a write");
  property p_vec_rise; $rose(shared_voltage_irq_vector) |-> voltage_detect_irq_request ||
    $past(wb_cyc_i && wb_stb_i && wb_we_i); endproperty
  a_vec_rise: assert property (p_vec_rise) else $error("vector rose without cause");
  property p_rst_cause; $rose(internal_reset_r) |-> hist_r != 8'h00; endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("internal reset without low supply");
  c_req: cover property (voltage_detect_irq_request);
  c_vec_clear: cover property ($fell(shared_voltage_irq_vector));
  c_int_reset: cover property ($rose(internal_reset_r));
endmodule // vdi_flags_chk

bind vdi_flags vdi_flags_chk chk_u (.*);

// >>> vdi_supply.sv
// Supply comparator model driving both detector inputs
`timescale 1ns/100ps
module vdi_supply (
  input wire logic clk,
  input wire logic cmd0,
  input wire logic cmd1,
  output logic det0_cmp_below,
  output logic det1_cmp_below
);
  // Supply starts above both thresholds
  initial
  begin
    det0_cmp_below = 1'b0;
    det1_cmp_below = 1'b0;
  end
  // Comparators follow the commanded supply one edge later
  always @(posedge clk)
  begin
    det0_cmp_below <= cmd0;
    det1_cmp_below <= cmd1;
  end
endmodule // vdi_supply

// >>> tb.sv
// Self-checking bench for the voltage detect flag block
`timescale 1ns/100ps
module tb;
  localparam int SETTLE = 8;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic ack, vec, req, int_rst, below0, below1;
  logic cmd0 = 1'b0;
  logic cmd1 = 1'b0;
  logic ir_seen = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  vdi_supply sup_u (.clk(clk), .cmd0(cmd0), .cmd1(cmd1), .det0_cmp_below(below0), .det1_cmp_below(below1));
  vdi_flags #(.SETTLE_CYC(SETTLE)) dut_u (.clk(clk), .resetn(resetn), .det0_cmp_below(below0),
    .det1_cmp_below(below1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .shared_voltage_irq_vector(vec),
    .voltage_detect_irq_request(req), .internal_reset_r(int_rst));
  // Remember any internal reset pulse
  always @(posedge clk) if (int_rst === 1'b1) ir_seen <= 1'b1;
  function automatic logic [31:0] bt(input int p);
    return 32'h1 << p;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    // Wait for the answer; only the watchdog ends a hung cycle
    while (ack !== 1'b1)
    begin
      @(posedge clk);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    while (req !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, req}, 32'h1);
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  // Handler-style sequences: read flags first, then clear
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(vdi_pkg::CTRL_OFS, 32'h0);
    rd(vdi_pkg::MASK_OFS, 32'h3);
    rd(vdi_pkg::STATUS_OFS, 32'h0);
    rd(4'h2, 32'h0);
    // A write without byte lane zero is ignored
    sel <= 4'hE;
    wb(1'b1, vdi_pkg::MASK_OFS, 32'h0);
    sel <= 4'hF;
    rd(vdi_pkg::MASK_OFS, 32'h3);
    cmd0 <= 1'b1;
    wait_req();
    check({31'h0, vec}, 32'h1);
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET0_SEEN) | bt(vdi_pkg::ST_DET0_BELOW));
    wb(1'b1, vdi_pkg::CLEAR_OFS, bt(vdi_pkg::CLR_DET0));
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET0_BELOW));
    check({31'h0, vec}, 32'h0);
    rd(vdi_pkg::CLEAR_OFS, 32'h0);
    cmd0 <= 1'b0;
    wait_req();
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET0_SEEN));
    wb(1'b1, vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET0_SEEN));
    rd(vdi_pkg::STATUS_OFS, 32'h0);
    wb(1'b1, vdi_pkg::CTRL_OFS, bt(vdi_pkg::CTRL_DET1_ENABLE));
    repeat (SETTLE + 4) @(posedge clk);
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET1_READY));
    wb(1'b1, vdi_pkg::MASK_OFS, 32'h1);
    cmd1 <= 1'b1;
    wait_req();
    check({31'h0, vec}, 32'h0);
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET1_SEEN) | bt(vdi_pkg::ST_DET1_BELOW) | bt(vdi_pkg::ST_DET1_READY));
    wb(1'b1, vdi_pkg::MASK_OFS, 32'h3);
    check({31'h0, vec}, 32'h1);
    wb(1'b1, vdi_pkg::CLEAR_OFS, 32'h3);
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET1_BELOW) | bt(vdi_pkg::ST_DET1_READY));
    // Rise back above; the clear lands in the very cycle of the event
    cmd1 <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, vdi_pkg::CLEAR_OFS, 32'h3);
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET1_SEEN) | bt(vdi_pkg::ST_DET1_READY));
    cmd1 <= 1'b1;
    wait_req();
    wb(1'b1, vdi_pkg::CLEAR_OFS, 32'h3);
    wb(1'b1, vdi_pkg::CTRL_OFS, bt(vdi_pkg::CTRL_DET1_RESET_MODE) | bt(vdi_pkg::CTRL_DET1_ENABLE));
    repeat (SETTLE + 8) @(posedge clk);
    check({31'h0, ir_seen}, 32'h1);
    rd(vdi_pkg::CTRL_OFS, bt(vdi_pkg::CTRL_DET0_RESET_MODE) | bt(vdi_pkg::CTRL_DET1_RESET_MODE));
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET0_RESET_MODE));
    cmd0 <= 1'b1;
    repeat (8) @(posedge clk);
    check({31'h0, int_rst}, 32'h1);
    rd(vdi_pkg::STATUS_OFS, bt(vdi_pkg::ST_DET0_BELOW) | bt(vdi_pkg::ST_DET0_RESET_MODE) | bt(vdi_pkg::ST_INT_RESET));
    cmd0 <= 1'b0;
    repeat (8) @(posedge clk);
    check({31'h0, int_rst}, 32'h0);
    stop_test();
  end
endmodule // tb
